//--- hw/std_csr_map.svh
// Register numbers, field positions, write masks and reset values of the trap delegation block.
`ifndef STD_CSR_MAP_SVH
`define STD_CSR_MAP_SVH
`define STD_CSR_S_STATUS 12'h100
`define STD_CSR_S_IRQ_EN 12'h104
`define STD_CSR_STVEC 12'h105
`define STD_CSR_SCAUSE 12'h142
`define STD_CSR_SIP 12'h144
`define STD_CSR_MSTATUS 12'h300
`define STD_CSR_EXC_DELEG 12'h302
`define STD_CSR_IRQ_DELEG 12'h303
`define STD_IDELEG_MASK 64'h0000_0000_0000_0222
`define STD_EDELEG_MASK 64'h0000_0000_0000_b3ff
`define STD_S_STATUS_MASK 64'h0000_0000_0000_0122
`define STD_MSTATUS_MASK 64'h0000_0000_0000_19aa
`define STD_S_IRQ_EN_MASK 64'h0000_0000_0000_0222
`define STD_SIP_MASK 64'h0000_0000_0000_0222
`define STD_STVEC_MASK 64'hffff_ffff_ffff_fffd
`define STD_ALL_MASK 64'hffff_ffff_ffff_ffff
`define STD_ZERO 64'h0000_0000_0000_0000
`define STD_ST_S_EN 1
`define STD_ST_MIE 3
`define STD_ST_S_PREV_EN 5
`define STD_ST_MPIE 7
`define STD_ST_S_PREV_PRIV 8
`define STD_ST_MPP_LO 11
`define STD_ST_MPP_HI 12
`define STD_IRQ_SW 1
`define STD_IRQ_TIMER 5
`define STD_IRQ_EXT 9
`define STD_CAUSE_MSB 63
`define STD_PRIV_U 2'h0
`define STD_PRIV_S 2'h1
`define STD_PRIV_M 2'h3
`define STD_MODE_VEC 2'h1
`define STD_VEC_SHIFT 2
`define STD_CODE_SW 6'h01
`define STD_CODE_TIMER 6'h05
`define STD_CODE_EXT 6'h09
`endif

//--- hw/std_pkg.sv
// Types carried between the trap delegation block and the core.
package std_pkg;
  typedef struct packed {
    logic re;
    logic we;
    logic [11:0] addr;
    logic [63:0] wdata;
  } std_csr_req_t;
  typedef struct packed {
    logic valid;
    logic irq;
    logic [5:0] code;
  } std_trap_req_t;
  typedef struct packed {
    logic valid;
    logic to_s;
    logic [63:0] pc;
    logic [63:0] cause;
  } std_trap_resp_t;
  typedef struct packed {
    logic req;
    logic [5:0] code;
  } std_irq_t;
endpackage : std_pkg

//--- hw/std_trap_deleg.sv
// Supervisor trap delegation, supervisor status view and supervisor interrupt enables.
`include "std_csr_map.svh"

module std_trap_deleg (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register access from the core.
  input wire std_pkg::std_csr_req_t csr,
  output logic [63:0] csr_rdata,
  output logic csr_miss,
  // Current privilege and trap request from the core.
  input wire logic [1:0] priv,
  input wire std_pkg::std_trap_req_t trap,
  // Hardware pending levels for supervisor timer and external interrupts.
  input wire logic timer_irq_pending_hw,
  input wire logic external_irq_pending_hw,
  // Trap routing answer and supervisor interrupt request.
  output std_pkg::std_trap_resp_t trap_resp,
  output std_pkg::std_irq_t s_irq
);

  // Write mask of each register; zero for an unmapped number.
  function automatic logic [63:0] wmask(input logic [11:0] a);
    case (a)
      `STD_CSR_S_STATUS: wmask = `STD_S_STATUS_MASK;
      `STD_CSR_S_IRQ_EN: wmask = `STD_S_IRQ_EN_MASK;
      `STD_CSR_STVEC: wmask = `STD_STVEC_MASK;
      `STD_CSR_SCAUSE: wmask = `STD_ALL_MASK;
      `STD_CSR_SIP: wmask = `STD_SIP_MASK;
      `STD_CSR_MSTATUS: wmask = `STD_MSTATUS_MASK;
      `STD_CSR_EXC_DELEG: wmask = `STD_EDELEG_MASK;
      `STD_CSR_IRQ_DELEG: wmask = `STD_IDELEG_MASK;
      default: wmask = `STD_ZERO;
    endcase
  endfunction : wmask

  // True for a register number that this block answers.
  function automatic logic hit(input logic [11:0] a);
    hit = (wmask(a) != `STD_ZERO);
  endfunction : hit

  // Merge written data into the old value under the register's mask.
  function automatic logic [63:0] merge(input logic [63:0] old, input logic [63:0] d,
                                        input logic [11:0] a);
    merge = (old & ~wmask(a)) | (d & wmask(a));
  endfunction : merge

  logic [63:0] ideleg_reg, ideleg_next;
  logic [63:0] edeleg_reg, edeleg_next;
  logic [63:0] status_reg, status_next;
  logic [63:0] s_en_reg, s_en_next;
  logic [63:0] sip_reg, sip_next;
  logic [63:0] stvec_reg, stvec_next;
  logic [63:0] scause_reg, scause_next;
  logic [63:0] rdata_reg, rdata_next;
  logic miss_reg, miss_next;
  std_pkg::std_trap_resp_t resp_reg, resp_next;
  std_pkg::std_irq_t irq_reg, irq_next;
  logic [63:0] pend_all;
  logic [63:0] irq_active;
  logic deleg_bit;
  logic to_s;
  logic glob_en;
  logic [63:0] vec_base;

  // Pending view merges software-held bits with the hardware levels.
  always_comb begin
    pend_all = sip_reg;
    pend_all[`STD_IRQ_TIMER] = sip_reg[`STD_IRQ_TIMER] | timer_irq_pending_hw;
    pend_all[`STD_IRQ_EXT] = sip_reg[`STD_IRQ_EXT] | external_irq_pending_hw;
    pend_all = pend_all & `STD_SIP_MASK;
  end

  // Routing decision: the cause code indexes the matching delegation mask.
  always_comb begin
    deleg_bit = trap.irq ? ideleg_reg[trap.code] : edeleg_reg[trap.code];
    to_s = deleg_bit && (priv != `STD_PRIV_M);
    vec_base = {stvec_reg[63:2], 2'b00};
  end

  // Supervisor interrupt gating by global enable, individual enable and delegation.
  always_comb begin
    irq_active = pend_all & s_en_reg & ideleg_reg;
    glob_en = (priv == `STD_PRIV_U) ||
              ((priv == `STD_PRIV_S) && status_reg[`STD_ST_S_EN]);
  end

  // Next values of the register file, trap entry after software writes.
  always_comb begin
    ideleg_next = ideleg_reg;
    edeleg_next = edeleg_reg;
    status_next = status_reg;
    s_en_next = s_en_reg;
    sip_next = sip_reg;
    stvec_next = stvec_reg;
    scause_next = scause_reg;
    if (csr.we) begin
      unique case (csr.addr)
        `STD_CSR_IRQ_DELEG: ideleg_next = merge(ideleg_reg, csr.wdata, csr.addr);
        `STD_CSR_EXC_DELEG: edeleg_next = merge(edeleg_reg, csr.wdata, csr.addr);
        `STD_CSR_S_STATUS,
        `STD_CSR_MSTATUS: status_next = merge(status_reg, csr.wdata, csr.addr);
        `STD_CSR_S_IRQ_EN: s_en_next = merge(s_en_reg, csr.wdata, csr.addr);
        `STD_CSR_SIP: sip_next = merge(sip_reg, csr.wdata, csr.addr);
        `STD_CSR_STVEC: stvec_next = merge(stvec_reg, csr.wdata, csr.addr);
        `STD_CSR_SCAUSE: scause_next = merge(scause_reg, csr.wdata, csr.addr);
        default: ;
      endcase
    end
    if (trap.valid) begin
      if (to_s) begin
        scause_next = {trap.irq, 57'h0, trap.code};
        status_next[`STD_ST_S_PREV_EN] = status_reg[`STD_ST_S_EN];
        status_next[`STD_ST_S_EN] = 1'b0;
        status_next[`STD_ST_S_PREV_PRIV] = priv[0];
      end else begin
        status_next[`STD_ST_MPIE] = status_reg[`STD_ST_MIE];
        status_next[`STD_ST_MIE] = 1'b0;
        status_next[`STD_ST_MPP_HI:`STD_ST_MPP_LO] = priv;
      end
    end
  end

  // Next values of the outputs: read data, trap answer and interrupt request.
  always_comb begin
    rdata_next = rdata_reg;
    miss_next = miss_reg;
    if (csr.re) begin
      miss_next = !hit(csr.addr);
      unique case (csr.addr)
        `STD_CSR_IRQ_DELEG: rdata_next = ideleg_reg;
        `STD_CSR_EXC_DELEG: rdata_next = edeleg_reg;
        `STD_CSR_S_STATUS: rdata_next = status_reg & `STD_S_STATUS_MASK;
        `STD_CSR_MSTATUS: rdata_next = status_reg & `STD_MSTATUS_MASK;
        `STD_CSR_S_IRQ_EN: rdata_next = s_en_reg;
        `STD_CSR_SIP: rdata_next = pend_all;
        `STD_CSR_STVEC: rdata_next = stvec_reg;
        `STD_CSR_SCAUSE: rdata_next = scause_reg;
        default: rdata_next = `STD_ZERO;
      endcase
    end
    resp_next.valid = trap.valid;
    resp_next.to_s = trap.valid && to_s;
    resp_next.cause = {trap.irq, 57'h0, trap.code};
    if (trap.irq && (stvec_reg[1:0] == `STD_MODE_VEC)) begin
      resp_next.pc = vec_base + {56'h0, trap.code, 2'b00};
    end else begin
      resp_next.pc = vec_base;
    end
    irq_next.req = (irq_active != `STD_ZERO) && glob_en;
    if (irq_active[`STD_IRQ_EXT]) begin
      irq_next.code = `STD_CODE_EXT;
    end else if (irq_active[`STD_IRQ_SW]) begin
      irq_next.code = `STD_CODE_SW;
    end else if (irq_active[`STD_IRQ_TIMER]) begin
      irq_next.code = `STD_CODE_TIMER;
    end else begin
      irq_next.code = 6'h00;
    end
  end

  // State registers; reset loads zero even with the clock enable low, otherwise everything holds while it is low.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ideleg_reg <= `STD_ZERO;
      edeleg_reg <= `STD_ZERO;
      status_reg <= `STD_ZERO;
      s_en_reg <= `STD_ZERO;
      sip_reg <= `STD_ZERO;
      stvec_reg <= `STD_ZERO;
      scause_reg <= `STD_ZERO;
      rdata_reg <= `STD_ZERO;
      miss_reg <= 1'b0;
      resp_reg <= '0;
      irq_reg <= '0;
    end else if (ce) begin
      ideleg_reg <= ideleg_next;
      edeleg_reg <= edeleg_next;
      status_reg <= status_next;
      s_en_reg <= s_en_next;
      sip_reg <= sip_next;
      stvec_reg <= stvec_next;
      scause_reg <= scause_next;
      rdata_reg <= rdata_next;
      miss_reg <= miss_next;
      resp_reg <= resp_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs straight from flip-flops.
  assign csr_rdata = rdata_reg;
  assign csr_miss = miss_reg;
  assign trap_resp = resp_reg;
  assign s_irq = irq_reg;

  // Checks on routing, register legality and trap entry.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_route_machine: assert property (ce && trap.valid && !deleg_bit |=>
    trap_resp.valid && !trap_resp.to_s) else $error("Undelegated trap not kept in machine mode.");
  a_route_exc_deleg: assert property (ce && trap.valid && !trap.irq &&
    edeleg_reg[trap.code] && priv != `STD_PRIV_M |=> trap_resp.to_s)
    else $error("Delegated exception not routed to supervisor.");
  a_route_index: assert property (ce && trap.valid && trap.irq |=>
    trap_resp.to_s == ($past(ideleg_reg[trap.code]) && $past(priv) != `STD_PRIV_M))
    else $error("Interrupt routing does not follow its code bit.");
  a_ideleg_legal: assert property ((ideleg_reg & ~`STD_IDELEG_MASK) == `STD_ZERO)
    else $error("Reserved interrupt delegation bit set.");
  a_edeleg_legal: assert property ((edeleg_reg & ~`STD_EDELEG_MASK) == `STD_ZERO)
    else $error("Reserved exception delegation bit set.");
  a_edeleg_gap: assert property (edeleg_reg[11:10] == 2'b00)
    else $error("Exception delegation bits 10 or 11 set.");
  a_sip_forward: assert property (ce && csr.we && csr.addr == `STD_CSR_SIP &&
    csr.wdata[`STD_IRQ_SW] |=> sip_reg[`STD_IRQ_SW])
    else $error("Pending write did not raise software interrupt.");
  a_status_alias: assert property (ce && csr.we && csr.addr == `STD_CSR_S_STATUS &&
    !trap.valid |=> status_reg[`STD_ST_S_PREV_PRIV] == $past(csr.wdata[`STD_ST_S_PREV_PRIV]) &&
    status_reg[`STD_ST_MIE] == $past(status_reg[`STD_ST_MIE]))
    else $error("Supervisor status write not seen in machine status.");
  a_irq_gate: assert property (ce && priv == `STD_PRIV_S && !status_reg[`STD_ST_S_EN] |=>
    !s_irq.req) else $error("Supervisor interrupt raised while globally disabled.");
  a_en_legal: assert property ((s_en_reg & ~`STD_S_IRQ_EN_MASK) == `STD_ZERO)
    else $error("Reserved enable bit set.");
  a_cause_top: assert property (ce && trap.valid && to_s |=>
    scause_reg[`STD_CAUSE_MSB] == $past(trap.irq) && scause_reg[5:0] == $past(trap.code))
    else $error("Supervisor cause not recorded.");
  a_vector_pc: assert property (ce && trap.valid && trap.irq &&
    stvec_reg[1:0] == `STD_MODE_VEC |=> trap_resp.pc == $past(vec_base) + {$past(trap.code), 2'b00})
    else $error("Vectored target address wrong.");
  a_trap_entry: assert property (ce && trap.valid && to_s |=>
    !status_reg[`STD_ST_S_EN] &&
    status_reg[`STD_ST_S_PREV_EN] == $past(status_reg[`STD_ST_S_EN]))
    else $error("Supervisor trap entry did not save the enable.");

  // Interrupt delegation routes delegated interrupts out of machine mode.
  a_route_irq_deleg: assert property (ce && trap.valid && trap.irq &&
    ideleg_reg[trap.code] && priv != `STD_PRIV_M |=> trap_resp.to_s)
    else $error("Delegated interrupt not routed to supervisor.");

  // The answer carries the cause with the interrupt flag on top.
  a_resp_cause: assert property (ce && trap.valid |=>
    trap_resp.cause[`STD_CAUSE_MSB] == $past(trap.irq))
    else $error("Trap answer cause flag wrong.");

  // Exceptions always use the base address, in either vector mode.
  a_direct_pc: assert property (ce && trap.valid && !trap.irq |=>
    trap_resp.pc == $past(vec_base))
    else $error("Exception target is not the base address.");

  // The trap answer is a pulse that only follows a trap.
  a_resp_pulse: assert property (ce && !trap.valid |=> !trap_resp.valid)
    else $error("Trap answer without a trap.");

  // Pending register keeps only its three writable bits.
  a_sip_legal: assert property ((sip_reg & ~`STD_SIP_MASK) == `STD_ZERO)
    else $error("Reserved pending bit set.");

  // Reads through the supervisor status view hide machine fields.
  a_status_hidden: assert property (ce && csr.re && csr.addr == `STD_CSR_S_STATUS |=>
    (csr_rdata & ~`STD_S_STATUS_MASK) == `STD_ZERO)
    else $error("Machine field visible in supervisor status view.");

  // No supervisor interrupt request while running in machine mode.
  a_irq_machine: assert property (ce && priv == `STD_PRIV_M |=> !s_irq.req)
    else $error("Supervisor interrupt raised in machine mode.");

  // No request without a pending, enabled and delegated interrupt.
  a_irq_needs_en: assert property (ce && irq_active == `STD_ZERO |=> !s_irq.req)
    else $error("Supervisor interrupt raised without an enabled source.");

  // A low clock enable freezes state and outputs.
  a_hold_ce: assert property (!ce |=> $stable(status_reg) && $stable(resp_reg) &&
    $stable(irq_reg)) else $error("State moved while clock enable low.");

  c_s_trap: cover property (ce && trap.valid && to_s ##1 trap_resp.to_s);
  c_m_trap: cover property (ce && trap.valid && !to_s);
  c_s_irq: cover property (s_irq.req && s_irq.code == `STD_CODE_TIMER);
  c_vectored: cover property (ce && trap.valid && trap.irq && stvec_reg[0]);

endmodule : std_trap_deleg

//--- verif/std_core_model.sv
// Core-side model that issues register accesses, traps and privilege changes.
module std_core_model (
  // Clock.
  input wire logic sys_clk,
  // Requests toward the block.
  output std_pkg::std_csr_req_t csr,
  output logic [1:0] priv,
  output std_pkg::std_trap_req_t trap,
  // Answers from the block.
  input wire logic [63:0] csr_rdata,
  input wire logic csr_miss,
  input wire std_pkg::std_trap_resp_t trap_resp
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero; user mode after reset.
  initial begin
    csr = '0;
    priv = 2'h0;
    trap = '0;
  end

  // Write one word; released fields show the inverse so stale values never pass.
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    csr <= {1'b0, 1'b1, a, d};
    @(posedge sys_clk);
    csr <= {2'b00, ~a, ~d};
  endtask : wr

  // Read one word; data and miss flag are taken once the accepting edge has landed.
  task automatic rd(input logic [11:0] a, output logic [63:0] d, output logic m);
    @(posedge sys_clk);
    csr <= {1'b1, 1'b0, a, 64'h0};
    @(posedge sys_clk);
    csr <= {2'b00, ~a, 64'hffff_ffff_ffff_ffff};
    #1;
    d = csr_rdata;
    m = csr_miss;
  endtask : rd

  // One-cycle trap pulse; the routing answer follows one edge later.
  task automatic take_trap(input logic i, input logic [5:0] c, output std_pkg::std_trap_resp_t r);
    @(posedge sys_clk);
    trap <= {1'b1, i, c};
    @(posedge sys_clk);
    trap <= {1'b0, ~i, ~c};
    #1;
    r = trap_resp;
  endtask : take_trap

  // Privilege change, launched on a rising edge.
  task automatic set_priv(input logic [1:0] p);
    @(posedge sys_clk);
    priv <= p;
  endtask : set_priv
endmodule : std_core_model

//--- verif/test_std_trap_deleg.sv
// Self-checking bench for the trap delegation block.
module test_std_trap_deleg;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [11:0] a;
    logic [63:0] w;
    logic [63:0] e;
    logic m;
  } std_row_t;
  localparam logic [11:0] a_st = 12'h100;
  localparam logic [11:0] a_en = 12'h104;
  localparam logic [11:0] a_vec = 12'h105;
  localparam logic [11:0] a_pend = 12'h144;
  localparam logic [15:0] edel_exp = 16'hb3ff;
  localparam logic [15:0] idel_exp = 16'h0222;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic tip_hw = 1'b0;
  logic eip_hw = 1'b0;
  std_pkg::std_csr_req_t csr;
  std_pkg::std_trap_req_t trap;
  std_pkg::std_trap_resp_t trap_resp;
  std_pkg::std_trap_resp_t r;
  std_pkg::std_irq_t s_irq;
  logic [63:0] csr_rdata;
  logic [63:0] d;
  logic csr_miss;
  logic m;
  logic [1:0] priv;
  int fail_count = 0;
  int check_count = 0;
  std_row_t rows [7] = '{
    '{12'h303, '1, 64'h222, 1'b0}, '{12'h302, '1, 64'hb3ff, 1'b0},
    '{12'h104, '1, 64'h222, 1'b0}, '{12'h100, '1, 64'h122, 1'b0},
    '{12'h144, '1, 64'h222, 1'b0}, '{12'h105, '1, 64'hffff_ffff_ffff_fffd, 1'b0},
    '{12'h7ff, '1, 64'h0, 1'b1}};

  // Clock at 20 MHz.
  always #25 sys_clk = ~sys_clk;

  std_trap_deleg DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .csr(csr),
    .csr_rdata(csr_rdata), .csr_miss(csr_miss), .priv(priv), .trap(trap),
    .timer_irq_pending_hw(tip_hw), .external_irq_pending_hw(eip_hw),
    .trap_resp(trap_resp), .s_irq(s_irq));

  std_core_model u_core (.sys_clk(sys_clk), .csr(csr), .priv(priv), .trap(trap),
    .csr_rdata(csr_rdata), .csr_miss(csr_miss), .trap_resp(trap_resp));

  // Compares one value and counts the outcome.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Waits one edge so the registered interrupt request reflects the last change.
  task automatic irq_is(input logic [63:0] exp);
    @(posedge sys_clk);
    #1;
    check(64'(s_irq), exp);
  endtask : irq_is

  // Cuts a hang short.
  initial begin
    repeat (4000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset value and write mask for six registers (not cause or machine status), and refusal of an unmapped number.
    foreach (rows[i]) begin
      u_core.rd(rows[i].a, d, m);
      check(d, 64'h0);
      check(64'(m), 64'(rows[i].m));
      u_core.wr(rows[i].a, rows[i].w);
      u_core.rd(rows[i].a, d, m);
      check(d, rows[i].e);
      check(64'(m), 64'(rows[i].m));
    end
    // Machine and supervisor status views alias each other.
    u_core.wr(12'h300, '1);
    u_core.rd(a_st, d, m);
    check(d, 64'h122);
    u_core.rd(12'h300, d, m);
    check(d, 64'h19aa);
    u_core.wr(a_st, 64'h0);
    u_core.rd(12'h300, d, m);
    check(d, 64'h1888);
    // Delegated exception from supervisor mode: target, cause and status entry.
    u_core.set_priv(2'h1);
    u_core.wr(a_vec, 64'h1000);
    u_core.wr(a_st, 64'h2);
    u_core.take_trap(1'b0, 6'h02, r);
    check(64'({r.valid, r.to_s}), 64'h3);
    check(r.pc, 64'h1000);
    check(r.cause, 64'h2);
    u_core.rd(a_st, d, m);
    check(d, 64'h120);
    u_core.rd(12'h142, d, m);
    check(d, 64'h2);
    // Vectored mode moves interrupts only.
    u_core.wr(a_vec, 64'h1001);
    u_core.take_trap(1'b1, 6'h05, r);
    check(64'(r.to_s), 64'h1);
    check(r.pc, 64'h1014);
    check(r.cause, 64'h8000_0000_0000_0005);
    u_core.take_trap(1'b0, 6'h02, r);
    check(r.pc, 64'h1000);
    // A trap taken in machine mode never goes to supervisor mode.
    u_core.set_priv(2'h3);
    u_core.take_trap(1'b0, 6'h02, r);
    check(64'(r.to_s), 64'h0);
    // Cause codes 0 to 15, exception and interrupt, from user mode.
    u_core.set_priv(2'h0);
    for (int i = 0; i < 16; i++) begin
      u_core.take_trap(1'b0, 6'(i), r);
      check(64'(r.to_s), 64'(edel_exp[i]));
      u_core.take_trap(1'b1, 6'(i), r);
      check(64'(r.to_s), 64'(idel_exp[i]));
    end
    // Supervisor-mode write of the timer pending bit raises the supervisor interrupt.
    u_core.set_priv(2'h1);
    u_core.wr(a_pend, 64'h0);
    u_core.wr(a_en, 64'h20);
    u_core.wr(a_st, 64'h2);
    u_core.wr(a_pend, 64'h20);
    irq_is(64'h45);
    u_core.wr(a_st, 64'h0);
    irq_is(64'h05);
    u_core.set_priv(2'h0);
    irq_is(64'h45);
    @(posedge sys_clk);
    eip_hw <= 1'b1;
    u_core.wr(a_en, 64'h220);
    irq_is(64'h49);
    // Hardware timer level alone raises the timer interrupt.
    u_core.wr(a_pend, 64'h0);
    eip_hw <= 1'b0;
    tip_hw <= 1'b1;
    irq_is(64'h45);
    u_core.wr(12'h303, 64'h0);
    @(posedge sys_clk);
    #1;
    check(64'(s_irq.req), 64'h0);
    // Clock enable low: a trap pulse is not taken.
    @(posedge sys_clk);
    ce <= 1'b0;
    u_core.take_trap(1'b0, 6'h02, r);
    check(64'(r.valid), 64'h0);
    ce <= 1'b1;
    final_report();
  end
endmodule : test_std_trap_deleg
